// ==== crs_pkg.sv ====
// crs_pkg: constants and types shared by the cpu register set files
// assumes a single core clock domain
package crs_pkg;
   localparam int CRS_W = 32;
   localparam int CRS_MODW = 16;
   localparam int CRS_PSWW = 16;
   localparam int CRS_NGPR = 8;
   localparam int CRS_NREG = 21;
   // status word bit positions
   localparam int PSW_C = 0;
   localparam int PSW_T = 1;
   localparam int PSW_L = 2;
   localparam int PSW_V = 4;
   localparam int PSW_F = 5;
   localparam int PSW_Z = 6;
   localparam int PSW_N = 7;
   localparam int PSW_U = 8;
   localparam int PSW_S = 9;
   localparam int PSW_P = 10;
   localparam int PSW_I = 11;
   localparam logic [15:0] PSW_RST = 16'h0000;
   localparam logic [15:0] PSW_LO_MASK = 16'h00FF;
   // configuration bit positions
   localparam int CFG_I = 0;
   localparam int CFG_F = 1;
   localparam int CFG_M = 2;
   localparam int CFG_C = 3;
   localparam int CFG_DE = 8;
   localparam int CFG_DC = 9;
   localparam int CFG_LDC = 10;
   localparam int CFG_IC = 11;
   localparam int CFG_LIC = 12;
   localparam logic [31:0] CFG_ONES = 32'h000000F0;
   localparam logic [31:0] CFG_IMPL = 32'h00001FFF;
   localparam logic [31:0] CFG_SHORT = 32'h0000000F;
   localparam logic [31:0] CFG_RST = 32'h000000F0;
   localparam logic [31:0] CRS_ZERO = 32'h00000000;
   // operand sizes
   typedef enum logic [1:0] {
      CRS_SZ_B = 2'b00,
      CRS_SZ_W = 2'b01,
      CRS_SZ_D = 2'b11
   } crs_size_e;
   // processor register selectors for the load/store register ops
   typedef enum logic [3:0] {
      CRS_PR_PC = 4'h0,
      CRS_PR_ISP = 4'h1,
      CRS_PR_USP = 4'h2,
      CRS_PR_FP = 4'h3,
      CRS_PR_SB = 4'h4,
      CRS_PR_BASE = 4'h5,
      CRS_PR_MOD = 4'h6,
      CRS_PR_PSW = 4'h7,
      CRS_PR_CFG = 4'h8,
      CRS_PR_SP = 4'h9
   } crs_preg_e;
   // stack operations
   typedef enum logic [1:0] {
      CRS_STK_NONE = 2'b00,
      CRS_STK_PUSH = 2'b01,
      CRS_STK_POP = 2'b10
   } crs_stk_e;
   localparam logic [31:0] CRS_LEN_B = 32'h00000001;
   localparam logic [31:0] CRS_LEN_W = 32'h00000002;
   localparam logic [31:0] CRS_LEN_D = 32'h00000004;
   localparam logic [15:0] CRS_H_LO = 16'h00FF;
endpackage

// ==== crs_flag_if.sv ====
// crs_flag_if: condition flag bundle between the flag unit and the top
// assumes both ends share clk_sys
`timescale 1ns/10ps
`default_nettype none
interface crs_flag_if;
   logic upd_c;
   logic c;
   logic upd_cmp;
   logic l;
   logic z;
   logic n;
   logic upd_f;
   logic f;
   logic ovf;
   modport unit (output upd_c, c, upd_cmp, l, z, n, upd_f, f, ovf);
   modport regs (input upd_c, c, upd_cmp, l, z, n, upd_f, f, ovf);
endinterface
`default_nettype wire

// ==== crs_flag_unit.sv ====
// crs_flag_unit: derives condition flags from alu and compare results
// assumes results arrive from the pipeline on the same clock
`timescale 1ns/10ps
`default_nettype none
module crs_flag_unit
   import crs_pkg::*;
(
   input wire logic arith_vld,
   input wire logic arith_carry,
   input wire logic arith_ovf,
   input wire logic cmp_vld,
   input wire logic cmp_float,
   input wire logic [31:0] cmp_a,
   input wire logic [31:0] cmp_b,
   crs_flag_if.unit fl
);
   always_comb begin
      fl.upd_c = arith_vld;
      fl.c = arith_carry;
      fl.upd_cmp = cmp_vld;
      fl.z = (cmp_b == cmp_a);
      fl.l = !cmp_float && (cmp_b < cmp_a);
      fl.n = ($signed(cmp_b) < $signed(cmp_a));
      fl.upd_f = arith_vld;
      fl.f = arith_ovf;
      fl.ovf = arith_vld && arith_ovf;
   end
endmodule
`default_nettype wire

// ==== crs_regs.sv ====
// crs_regs: architectural register set of the core
// assumes the pipeline issues at most one write per port per cycle
`timescale 1ns/10ps
`default_nettype none
module crs_regs
   import crs_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   // general register file
   input wire logic [2:0] gpr_rd_sel,
   output logic [31:0] gpr_rd_data,
   input wire logic gpr_wr,
   input wire logic [2:0] gpr_wr_sel,
   input wire crs_pkg::crs_size_e gpr_wr_size,
   input wire logic [31:0] gpr_wr_data,
   // address register writes from the pipeline
   input wire logic pc_wr,
   input wire logic [31:0] pc_nxt_in,
   input wire logic fp_wr,
   input wire logic sb_wr,
   input wire logic mod_wr,
   input wire logic sp_wr,
   input wire logic [31:0] areg_wr_data,
   // stack operations on the active pointer
   input wire crs_pkg::crs_stk_e stk_op,
   input wire crs_pkg::crs_size_e stk_size,
   output logic [31:0] stk_addr,
   // privileged processor register ops
   input wire logic lpr_vld,
   input wire logic spr_vld,
   input wire crs_pkg::crs_preg_e preg_sel,
   input wire logic [31:0] lpr_data,
   output logic [31:0] spr_data,
   input wire logic set_configuration_op_vld,
   input wire logic [3:0] set_configuration_op_short,
   input wire logic priv_op,
   output logic priv_fault,
   // condition results
   input wire logic arith_vld,
   input wire logic arith_carry,
   input wire logic arith_ovf,
   input wire logic cmp_vld,
   input wire logic cmp_float,
   input wire logic [31:0] cmp_a,
   input wire logic [31:0] cmp_b,
   // instruction flow and exceptions
   input wire logic instr_done,
   input wire logic exc_entry,
   input wire logic trace_taken,
   input wire logic int_req,
   input wire logic nmi_req,
   input wire logic fpu_op,
   input wire logic custom_op,
   output logic trace_trap,
   output logic overflow_trap,
   output logic undefined_instruction_trap,
   output logic slave_pass,
   output logic int_accept,
   output logic nmi_accept,
   output logic int_vectored,
   // visible state
   output logic [31:0] pc,
   output logic [31:0] sp,
   output logic [31:0] frame_pointer,
   output logic [31:0] static_base,
   output logic [31:0] dispatch_table_base,
   output logic [15:0] module_pointer,
   output logic [15:0] processor_status_word,
   output logic direct_exception_enable,
   output logic data_cache_enable,
   output logic data_cache_lock,
   output logic fetch_cache_enable,
   output logic fetch_cache_lock
);
   logic [31:0] gpr_r [CRS_NGPR];
   logic [31:0] pc_r, isp_r, usp_r, fp_r, sb_r, base_r;
   // module pointer kept at 16 bits
   logic [15:0] mod_r;
   logic [15:0] psw_r;
   logic [31:0] cfg_r;
   logic [31:0] len;
   logic [31:0] sp_cur;
   logic [31:0] sp_upd;
   logic stk_busy;
   logic supv;
   logic lpr_ok;
   logic [15:0] psw_wmask;
   crs_flag_if fl ();

   crs_flag_unit u_flag (
      .arith_vld(arith_vld),
      .arith_carry(arith_carry),
      .arith_ovf(arith_ovf),
      .cmp_vld(cmp_vld),
      .cmp_float(cmp_float),
      .cmp_a(cmp_a),
      .cmp_b(cmp_b),
      .fl(fl)
   );

   assign supv = !psw_r[PSW_U];
   // privileged ops refused in user mode
   assign priv_fault = priv_op && psw_r[PSW_U];
   assign lpr_ok = lpr_vld && supv;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         for (int i = 0; i < CRS_NGPR; i++) begin
            gpr_r[i] <= CRS_ZERO;
         end
      end else if (gpr_wr) begin
         unique case (gpr_wr_size)
            CRS_SZ_B: gpr_r[gpr_wr_sel][7:0] <= gpr_wr_data[7:0];
            CRS_SZ_W: gpr_r[gpr_wr_sel][15:0] <= gpr_wr_data[15:0];
            CRS_SZ_D: gpr_r[gpr_wr_sel] <= gpr_wr_data;
            default: gpr_r[gpr_wr_sel] <= gpr_r[gpr_wr_sel];
         endcase
      end
   end
   assign gpr_rd_data = gpr_r[gpr_rd_sel];

   always_comb begin
      unique case (stk_size)
         CRS_SZ_B: len = CRS_LEN_B;
         CRS_SZ_W: len = CRS_LEN_W;
         default: len = CRS_LEN_D;
      endcase
   end
   assign sp_cur = psw_r[PSW_S] ? usp_r : isp_r;
   assign stk_busy = (stk_op != CRS_STK_NONE);
   // push address is pre-decremented, pop uses current
   assign sp_upd = (stk_op == CRS_STK_PUSH) ? sp_cur - len : sp_cur + len;
   assign stk_addr = (stk_op == CRS_STK_PUSH) ? sp_upd : sp_cur;

   // stack pointers; stack ops win over plain writes in the same cycle
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         isp_r <= CRS_ZERO;
         usp_r <= CRS_ZERO;
      end else if (stk_busy) begin
         if (psw_r[PSW_S]) begin
            usp_r <= sp_upd;
         end else begin
            isp_r <= sp_upd;
         end
      end else if (sp_wr) begin
         if (psw_r[PSW_S]) begin
            usp_r <= areg_wr_data;
         end else begin
            isp_r <= areg_wr_data;
         end
      end else if (lpr_ok) begin
         if (preg_sel == CRS_PR_USP) begin
            usp_r <= lpr_data;
         end else if (preg_sel == CRS_PR_ISP) begin
            isp_r <= lpr_data;
         end else if (preg_sel == CRS_PR_SP) begin
            if (psw_r[PSW_S]) begin
               usp_r <= lpr_data;
            end else begin
               isp_r <= lpr_data;
            end
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pc_r <= CRS_ZERO;
      end else if (pc_wr) begin
         pc_r <= pc_nxt_in;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         fp_r <= CRS_ZERO;
         sb_r <= CRS_ZERO;
         base_r <= CRS_ZERO;
         mod_r <= CRS_ZERO[15:0];
      end else begin
         if (fp_wr) begin
            fp_r <= areg_wr_data;
         end else if (lpr_ok && preg_sel == CRS_PR_FP) begin
            fp_r <= lpr_data;
         end
         if (sb_wr) begin
            sb_r <= areg_wr_data;
         end else if (lpr_ok && preg_sel == CRS_PR_SB) begin
            sb_r <= lpr_data;
         end
         if (lpr_ok && preg_sel == CRS_PR_BASE) begin
            base_r <= lpr_data;
         end
         if (mod_wr) begin
            mod_r <= areg_wr_data[15:0];
         end else if (lpr_ok && preg_sel == CRS_PR_MOD) begin
            mod_r <= lpr_data[15:0];
         end
      end
   end

   // high byte writable only in supervisor
   assign psw_wmask = supv ? 16'hFFFF : PSW_LO_MASK;

   // status word: software load first, then hardware events override
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         psw_r <= PSW_RST;
      end else begin
         logic [15:0] p;
         p = psw_r;
         if (lpr_vld && preg_sel == CRS_PR_PSW) begin
            p = (psw_r & ~psw_wmask) | (lpr_data[15:0] & psw_wmask);
         end
         if (fl.upd_c) begin
            p[PSW_C] = fl.c;
         end
         if (fl.upd_f) begin
            p[PSW_F] = fl.f;
         end
         if (fl.upd_cmp) begin
            p[PSW_L] = fl.l;
            p[PSW_Z] = fl.z;
            p[PSW_N] = fl.n;
         end
         // pending cleared once the trace trap is taken
         if (trace_taken) begin
            p[PSW_P] = 1'b0;
         end
         // set wins so a fresh trap is never lost
         if (trace_trap) begin
            p[PSW_P] = 1'b1;
         end
         if (exc_entry) begin
            p[PSW_S] = 1'b0;
         end
         psw_r <= p;
      end
   end

   // configuration register
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cfg_r <= CFG_RST;
      end else if (set_configuration_op_vld && supv) begin
         // short field loads low nibble, clears 8-12
         cfg_r <= (CRS_ZERO | {28'h0000000, set_configuration_op_short}) | CFG_ONES;
      end else if (lpr_ok && preg_sel == CRS_PR_CFG) begin
         cfg_r <= (lpr_data & CFG_IMPL & ~CFG_ONES) | CFG_ONES;
      end
   end

   // store path
   always_comb begin
      spr_data = CRS_ZERO;
      if (spr_vld) begin
         unique case (preg_sel)
            CRS_PR_PC: spr_data = pc_r;
            CRS_PR_ISP: spr_data = isp_r;
            // user pointer readable whatever the select
            CRS_PR_USP: spr_data = usp_r;
            CRS_PR_FP: spr_data = fp_r;
            CRS_PR_SB: spr_data = sb_r;
            CRS_PR_BASE: spr_data = base_r;
            CRS_PR_MOD: spr_data = {16'h0000, mod_r};
            // high byte hidden from user mode
            CRS_PR_PSW: spr_data = {16'h0000, psw_r & psw_wmask};
            // bits 4-7 read back as ones
            CRS_PR_CFG: spr_data = cfg_r | CFG_ONES;
            CRS_PR_SP: spr_data = sp_cur;
            default: spr_data = CRS_ZERO;
         endcase
      end
   end

   // suppressed while a trace is already pending
   assign trace_trap = instr_done && psw_r[PSW_T] && !psw_r[PSW_P];
   assign overflow_trap = fl.ovf && psw_r[PSW_V];
   // missing slave traps, present slave passes
   assign undefined_instruction_trap = (fpu_op && !cfg_r[CFG_F]) ||
      (custom_op && !cfg_r[CFG_C]);
   assign slave_pass = (fpu_op && cfg_r[CFG_F]) ||
      (custom_op && cfg_r[CFG_C]);
   assign int_accept = int_req && psw_r[PSW_I];
   assign nmi_accept = nmi_req;
   assign int_vectored = cfg_r[CFG_I];

   assign pc = pc_r;
   assign sp = sp_cur;
   assign frame_pointer = fp_r;
   assign static_base = sb_r;
   assign dispatch_table_base = base_r;
   assign module_pointer = mod_r;
   assign processor_status_word = psw_r;
   assign direct_exception_enable = cfg_r[CFG_DE];
   assign data_cache_enable = cfg_r[CFG_DC];
   assign data_cache_lock = cfg_r[CFG_LDC];
   assign fetch_cache_enable = cfg_r[CFG_IC];
   assign fetch_cache_lock = cfg_r[CFG_LIC];
endmodule
`default_nettype wire

// ==== crs_exc_model.sv ====
// crs_exc_model: exception unit stand-in that acknowledges trace traps
// assumes trace_trap is sampled on clk_sys next to the register set
`timescale 1ns/10ps
`default_nettype none
module crs_exc_model (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic trace_trap,
   output logic trace_taken
);
   // one acknowledge per trap
   // ack a cycle late so the pending flag is seen set first
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         trace_taken <= 1'b0;
      end else begin
         trace_taken <= trace_trap && !trace_taken;
      end
   end
endmodule
`default_nettype wire

// ==== crs_regs_sva.sv ====
// crs_regs_sva: port-level checks of the register set
// assumes it is bound onto crs_regs, one clock, sync reset
`timescale 1ns/10ps
`default_nettype none
module crs_regs_sva
   import crs_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire crs_pkg::crs_stk_e stk_op,
   input wire crs_pkg::crs_size_e stk_size,
   input wire logic [31:0] stk_addr,
   input wire logic [31:0] sp,
   input wire logic exc_entry,
   input wire logic lpr_vld,
   input wire logic spr_vld,
   input wire crs_pkg::crs_preg_e preg_sel,
   input wire logic [31:0] spr_data,
   input wire logic mod_wr,
   input wire logic [31:0] areg_wr_data,
   input wire logic [15:0] module_pointer,
   input wire logic [15:0] processor_status_word,
   input wire logic cmp_vld,
   input wire logic cmp_float,
   input wire logic [31:0] cmp_a,
   input wire logic [31:0] cmp_b,
   input wire logic priv_op,
   input wire logic priv_fault,
   input wire logic trace_trap,
   input wire logic trace_taken,
   input wire logic instr_done
);
   wire [15:0] w = processor_status_word;
   wire [15:0] mlo = areg_wr_data[15:0];
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   a_priv_fault: assert property (
      priv_fault == (priv_op && w[8])) else $error("privilege fault wrong");
   a_push_addr: assert property (
      stk_op == CRS_STK_PUSH && stk_size == CRS_SZ_D |->
      stk_addr == sp - 32'h4) else $error("push address wrong");
   a_pop_step: assert property (
      stk_op == CRS_STK_POP && stk_size == CRS_SZ_W && !exc_entry &&
      !lpr_vld |=> sp == $past(sp) + 32'h2) else $error("pop step wrong");
   a_exc_clr_s: assert property (exc_entry |=> !w[9])
      else $error("stack select kept");
   a_mod_low: assert property (
      mod_wr && !lpr_vld |=> module_pointer == $past(mlo))
      else $error("module pointer wrong");
   a_cfg_ones: assert property (
      spr_vld && preg_sel == CRS_PR_CFG |-> spr_data[7:4] == 4'hF &&
      spr_data[31:13] == 19'h0) else $error("config readback wrong");
   a_cmp_zl: assert property (
      cmp_vld && !cmp_float |=> w[6] == ($past(cmp_a) == $past(cmp_b)) &&
      w[2] == ($past(cmp_b) < $past(cmp_a)))
      else $error("compare flags wrong");
   a_cmp_neg: assert property (
      cmp_vld && !cmp_float |=>
      w[7] == ($signed($past(cmp_b)) < $signed($past(cmp_a))))
      else $error("negative flag wrong");
   a_trace_gate: assert property (
      trace_trap == (instr_done && w[1] && !w[10]))
      else $error("trace trap wrong");
   a_trace_pend: assert property (
      trace_trap |=> w[10]) else $error("trace pending lost");
   a_trace_clr: assert property (
      trace_taken && !trace_trap |=> !w[10])
      else $error("trace pending stuck");
endmodule
`default_nettype wire

// ==== cpu_register_set_tb_top.sv ====
// cpu_register_set_tb_top: directed register set checks
// assumes package, design, model and checker compiled before
`timescale 1ns/10ps
`default_nettype none
module cpu_register_set_tb_top;
   import crs_pkg::*;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [9:0] pv = 10'h000;
   wire cmp_vld = pv[0], arith_vld = pv[1], exc_entry = pv[2];
   wire instr_done = pv[3], set_configuration_op_vld = pv[4], mod_wr = pv[5];
   wire fp_wr = pv[6], sb_wr = pv[7], gpr_wr = pv[8], lpr_vld = pv[9];
   logic pc_wr = 1'b0, sp_wr = 1'b0, spr_vld = 1'b0, priv_op = 1'b0;
   logic arith_carry = 1'b0, arith_ovf = 1'b0, cmp_float = 1'b0;
   logic int_req = 1'b0, nmi_req = 1'b0, fpu_op = 1'b0, custom_op = 1'b0;
   logic [2:0] gpr_rd_sel = 3'h3, gpr_wr_sel = 3'h3;
   logic [3:0] set_configuration_op_short = 4'h0;
   logic [31:0] pc_nxt_in = 32'h0, areg_wr_data = 32'h0, lpr_data = 32'h0;
   logic [31:0] gpr_wr_data = 32'h0, cmp_a = 32'h0, cmp_b = 32'h0;
   crs_size_e gpr_wr_size = CRS_SZ_D, stk_size = CRS_SZ_D;
   crs_stk_e stk_op = CRS_STK_NONE;
   crs_preg_e preg_sel = CRS_PR_PC;
   wire trace_taken;
   logic [31:0] gpr_rd_data, stk_addr, spr_data, pc, sp, frame_pointer;
   logic [31:0] static_base, dispatch_table_base;
   logic [15:0] module_pointer, processor_status_word;
   logic priv_fault, trace_trap, overflow_trap, undefined_instruction_trap;
   logic slave_pass, int_accept, nmi_accept, int_vectored;
   logic direct_exception_enable, data_cache_enable, data_cache_lock;
   logic fetch_cache_enable, fetch_cache_lock;
   wire [4:0] cch = {direct_exception_enable, data_cache_enable,
      data_cache_lock, fetch_cache_enable, fetch_cache_lock};
   wire [1:0] ex = {undefined_instruction_trap, slave_pass};
   wire [2:0] nzl = {processor_status_word[7], processor_status_word[6],
      processor_status_word[2]};
   logic [1:0] mid;
   logic [2:0] ex3;
   int fail_count = 0, checks = 0;
   logic [31:0] va[4] = '{32'h5, 32'h5, 32'h80000000, 32'h1};
   logic [31:0] vb[4] = '{32'h5, 32'h3, 32'h1, 32'hFFFFFFFF};
   crs_size_e sz[3] = '{CRS_SZ_D, CRS_SZ_B, CRS_SZ_W};
   logic [31:0] gd[3] = '{32'h11223344, 32'hFFFFFFAA, 32'hFFFFBEEF};
   logic [31:0] ge[3] = '{32'h11223344, 32'h112233AA, 32'h1122BEEF};
   crs_regs uut (.*);
   crs_exc_model pm (.*);
   always #5 clk_sys = ~clk_sys;
   task chk(input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         fail_count++;
         $display("BAD %0t %h %h", $time, s, e);
      end
   endtask
   task give_verdict;
      if (fail_count == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // one-cycle strobe; mid holds the traps seen while it is up
   task pulse(input logic [9:0] m);
      @(posedge clk_sys);
      pv <= m;
      #1 mid = {overflow_trap, trace_trap};
      @(posedge clk_sys);
      pv <= 10'h000;
      #1;
   endtask
   task lpr(input crs_preg_e s, input logic [31:0] d);
      @(posedge clk_sys);
      preg_sel <= s;
      lpr_data <= d;
      pulse(10'h200);
   endtask
   task spr(input crs_preg_e s, input logic [31:0] e);
      @(posedge clk_sys);
      spr_vld <= 1'b1;
      preg_sel <= s;
      #1 chk(spr_data, e);
      @(posedge clk_sys);
      spr_vld <= 1'b0;
      #1;
   endtask
   task stk(input crs_stk_e o, input crs_size_e z, input logic [31:0] e);
      @(posedge clk_sys);
      stk_op <= o;
      stk_size <= z;
      #1 chk(stk_addr, e);
      @(posedge clk_sys);
      stk_op <= CRS_STK_NONE;
      #1;
   endtask
   // hang guard: the whole run is far shorter than this
   initial begin
      #100000;
      fail_count++;
      give_verdict;
   end
   initial begin
      repeat (16) @(posedge clk_sys);
      rst <= 1'b0;
      spr(CRS_PR_CFG, CFG_RST);
      spr(CRS_PR_PSW, 32'h0);
      lpr(CRS_PR_CFG, 32'h00001F0B);
      spr(CRS_PR_CFG, 32'h00001FFB);
      chk(cch, 32'h1F);
      @(posedge clk_sys);
      set_configuration_op_short <= 4'h9;
      pulse(10'h010);
      spr(CRS_PR_CFG, 32'h000000F9);
      chk(cch, 32'h0);
      @(posedge clk_sys);
      fpu_op <= 1'b1;
      #1 chk(ex, 32'h2);
      @(posedge clk_sys);
      fpu_op <= 1'b0;
      custom_op <= 1'b1;
      #1 chk(ex, 32'h1);
      @(posedge clk_sys);
      custom_op <= 1'b0;
      for (int i = 0; i < 3; i++) begin
         @(posedge clk_sys);
         gpr_wr_size <= sz[i];
         gpr_wr_data <= gd[i];
         pulse(10'h100);
         chk(gpr_rd_data, ge[i]);
      end
      lpr(CRS_PR_ISP, 32'h100);
      lpr(CRS_PR_USP, 32'h200);
      spr(CRS_PR_USP, 32'h200);
      chk(sp, 32'h100);
      stk(CRS_STK_PUSH, CRS_SZ_D, 32'hFC);
      chk(sp, 32'hFC);
      stk(CRS_STK_POP, CRS_SZ_W, 32'hFC);
      chk(sp, 32'hFE);
      lpr(CRS_PR_PSW, 32'h200);
      chk(sp, 32'h200);
      pulse(10'h004);
      chk(processor_status_word[9], 32'h0);
      chk(sp, 32'hFE);
      @(posedge clk_sys);
      areg_wr_data <= 32'h12345678;
      pulse(10'h0E0);
      chk(module_pointer, 32'h5678);
      chk(frame_pointer, 32'h12345678);
      chk(static_base, 32'h12345678);
      lpr(CRS_PR_BASE, 32'hABCD0000);
      chk(dispatch_table_base, 32'hABCD0000);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_sys);
         cmp_a <= va[i];
         cmp_b <= vb[i];
         ex3 = {$signed(vb[i]) < $signed(va[i]), vb[i] == va[i],
            vb[i] < va[i]};
         pulse(10'h001);
         chk(nzl, ex3);
      end
      @(posedge clk_sys);
      cmp_float <= 1'b1;
      cmp_a <= 32'h5;
      cmp_b <= 32'h3;
      pulse(10'h001);
      chk(processor_status_word[2], 32'h0);
      @(posedge clk_sys);
      cmp_float <= 1'b0;
      lpr(CRS_PR_PSW, 32'h10);
      @(posedge clk_sys);
      arith_carry <= 1'b1;
      arith_ovf <= 1'b1;
      pulse(10'h002);
      chk(mid[1], 32'h1);
      chk(processor_status_word[5:0] & 6'h21, 32'h21);
      @(posedge clk_sys);
      arith_carry <= 1'b0;
      arith_ovf <= 1'b0;
      pulse(10'h002);
      chk({mid[1], processor_status_word[0]}, 32'h0);
      @(posedge clk_sys);
      int_req <= 1'b1;
      nmi_req <= 1'b1;
      #1 chk({int_accept, nmi_accept}, 32'h1);
      lpr(CRS_PR_PSW, 32'h810);
      chk({int_accept, int_vectored}, 32'h3);
      @(posedge clk_sys);
      int_req <= 1'b0;
      nmi_req <= 1'b0;
      lpr(CRS_PR_PSW, 32'h2);
      pulse(10'h008);
      chk(mid[0], 32'h1);
      chk(processor_status_word[10], 32'h1);
      lpr(CRS_PR_PSW, 32'h100);
      @(posedge clk_sys);
      priv_op <= 1'b1;
      #1 chk(priv_fault, 32'h1);
      @(posedge clk_sys);
      priv_op <= 1'b0;
      lpr(CRS_PR_PSW, 32'hF00);
      chk(processor_status_word, 32'h100);
      spr(CRS_PR_PSW, 32'h0);
      lpr(CRS_PR_CFG, 32'h0);
      spr(CRS_PR_CFG, 32'h000000F9);
      @(posedge clk_sys);
      pc_nxt_in <= 32'h00C0FFEE;
      pc_wr <= 1'b1;
      sp_wr <= 1'b1;
      @(posedge clk_sys);
      pc_wr <= 1'b0;
      sp_wr <= 1'b0;
      #1 chk(pc, 32'h00C0FFEE);
      chk(sp, 32'h12345678);
      spr(CRS_PR_PC, 32'h00C0FFEE);
      spr(CRS_PR_SP, 32'h12345678);
      spr(CRS_PR_MOD, 32'h00005678);
      give_verdict;
   end
endmodule
bind crs_regs crs_regs_sva u_sva (.*);
`default_nettype wire
